/* core/pec_pkg.sv */
/*
 Shared constants, carriers and the class decoder of the parser error classifier.
 Assumes one clock domain and signed 16-bit error codes throughout.
*/
package pec_pkg;
   // ==========================================================
   // Widths and limits
   localparam int CODE_W = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int QUEUE_DEPTH = 30;
   localparam int QPTR_W = 5;
   localparam logic [7:0] MAX_MNEM_LEN = 8'h0c;
   localparam logic [9:0] MAX_DIGITS = 10'h0ff;
   localparam logic [7:0] MAX_SFX_LEN = 8'h0c;

   typedef logic signed [CODE_W-1:0] pec_code_t;

   // ==========================================================
   // Error codes
   localparam pec_code_t NO_ERROR = 16'sh0000;
   localparam pec_code_t CMD_GENERIC = -16'sd100;
   localparam pec_code_t INVALID_CHAR = -16'sd101;
   localparam pec_code_t SYNTAX_ERR = -16'sd102;
   localparam pec_code_t INVALID_SEP = -16'sd103;
   localparam pec_code_t DATA_TYPE = -16'sd104;
   localparam pec_code_t TRIG_IN_MSG = -16'sd105;
   localparam pec_code_t PARAM_EXTRA = -16'sd108;
   localparam pec_code_t PARAM_MISSING = -16'sd109;
   localparam pec_code_t MNEM_LONG = -16'sd112;
   localparam pec_code_t UNDEF_HDR = -16'sd113;
   localparam pec_code_t NUM_GENERIC = -16'sd120;
   localparam pec_code_t NUM_BAD_CHAR = -16'sd121;
   localparam pec_code_t EXP_TOO_LARGE = -16'sd123;
   localparam pec_code_t TOO_MANY_DIGITS = -16'sd124;
   localparam pec_code_t NUM_NOT_ALLOWED = -16'sd128;
   localparam pec_code_t SFX_INVALID = -16'sd131;
   localparam pec_code_t SFX_LONG = -16'sd134;
   localparam pec_code_t CHAR_INVALID = -16'sd141;
   localparam pec_code_t CHAR_NOT_ALLOWED = -16'sd148;
   localparam pec_code_t STR_GENERIC = -16'sd150;
   localparam pec_code_t EXEC_GENERIC = -16'sd200;
   localparam pec_code_t DEV_GENERIC = -16'sd300;
   localparam pec_code_t QUEUE_OVERFLOW = -16'sd350;
   localparam pec_code_t QRY_GENERIC = -16'sd400;

   // Class ranges, high end is the smaller magnitude
   localparam pec_code_t CMD_HI = -16'sd100;
   localparam pec_code_t CMD_LO = -16'sd199;
   localparam pec_code_t EXEC_HI = -16'sd200;
   localparam pec_code_t EXEC_LO = -16'sd299;
   localparam pec_code_t DEV_HI = -16'sd300;
   localparam pec_code_t DEV_LO = -16'sd399;
   localparam pec_code_t QRY_HI = -16'sd400;
   localparam pec_code_t QRY_LO = -16'sd499;

   // ==========================================================
   // Register map and fields
   localparam logic [ADDR_W-1:0] REG_EVENT_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] REG_ERR_QUERY = 8'h04;
   localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h08;
   localparam logic [ADDR_W-1:0] REG_QUEUE_STATUS = 8'h0c;
   localparam int CTRL_CLEAR_BIT = 0;
   localparam int ESR_CMD_BIT = 5;
   localparam int ESR_EXEC_BIT = 4;
   localparam int ESR_DEV_BIT = 3;
   localparam int ESR_QRY_BIT = 2;
   localparam logic [7:0] ESR_RESET = 8'h00;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic cmdGeneric;
      logic invalidChar;
      logic syntaxErr;
      logic invalidSep;
      logic dataType;
      logic paramExtra;
      logic paramMissing;
      logic undefHdr;
      logic numGeneric;
      logic numBadChar;
      logic expTooLarge;
      logic numNotAllowed;
      logic sfxInvalid;
      logic charInvalid;
      logic charNotAllowed;
      logic strGeneric;
   } pec_syntax_s;

   typedef struct packed {
      logic strobe;
      logic [7:0] hdrLen;
      logic [9:0] digits;
      logic [7:0] sfxLen;
   } pec_len_s;

   typedef struct packed {
      logic valid;
      pec_code_t code;
   } pec_fault_s;

   // One-hot event status bit for a code, zero for no error
   function automatic logic [7:0] pec_class_mask(input pec_code_t c);
      logic [7:0] m;
      m = 8'h00;
      if (c <= CMD_HI && c >= CMD_LO) m[ESR_CMD_BIT] = 1'b1;
      if (c <= EXEC_HI && c >= EXEC_LO) m[ESR_EXEC_BIT] = 1'b1;
      if ((c <= DEV_HI && c >= DEV_LO) || c > NO_ERROR) m[ESR_DEV_BIT] = 1'b1;
      if (c <= QRY_HI && c >= QRY_LO) m[ESR_QRY_BIT] = 1'b1;
      return m;
   endfunction
endpackage

/* core/pec_err_queue.sv */
/*
 First-in first-out store of error codes with overflow marking.
 Assumes push, pop and clear are single-cycle requests from the classifier.
*/
`timescale 1ns/1ps
module pec_err_queue
   import pec_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clr,
   input wire logic push,
   input pec_code_t pushCode,
   input wire logic pop,
   output pec_code_t headCode,
   output logic [QPTR_W-1:0] count
);
   // ==========================================================
   // Storage and pointers
   pec_code_t mem [QUEUE_DEPTH];
   logic [QPTR_W-1:0] rdPtr_reg, wrPtr_reg, count_reg;
   logic [QPTR_W-1:0] rdPtr_next, wrPtr_next, count_next, afterPop, wrIdx;
   logic doPop, doPush;
   pec_code_t storeCode;

   // Pop first, so a read in the same cycle opens a slot for the push
   assign doPop = pop && count_reg != '0 && !clr;
   assign afterPop = clr ? '0 : count_reg - QPTR_W'(doPop);
   assign doPush = push && afterPop < QPTR_W'(QUEUE_DEPTH);
   // Last free slot takes the overflow marker, later faults are dropped
   assign storeCode = (afterPop == QPTR_W'(QUEUE_DEPTH - 1)) ? QUEUE_OVERFLOW : pushCode;
   assign wrIdx = clr ? '0 : wrPtr_reg;
   assign rdPtr_next = clr ? '0 : !doPop ? rdPtr_reg :
                       (rdPtr_reg == QPTR_W'(QUEUE_DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
   assign wrPtr_next = !doPush ? wrIdx :
                       (wrIdx == QPTR_W'(QUEUE_DEPTH - 1)) ? '0 : wrIdx + 1'b1;
   assign count_next = afterPop + QPTR_W'(doPush);
   assign headCode = (count_reg == '0) ? NO_ERROR : mem[rdPtr_reg];
   assign count = count_reg;

   // Pointer and fill state
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdPtr_reg <= '0;
         wrPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         rdPtr_reg <= rdPtr_next;
         wrPtr_reg <= wrPtr_next;
         count_reg <= count_next;
      end
   end

   // Data array needs no reset, the fill count guards every read
   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[wrIdx] <= storeCode;
      end
   end
endmodule

/* core/pec_classifier.sv */
/*
 Parser error classifier: turns parser, execution, device and query faults
 into signed error codes, sets the event status class bits, queues codes.
 Assumes fault inputs are one-cycle pulses synchronous to clk, and a simple
 register port with read data returned in the cycle after the read strobe.
*/
`timescale 1ns/1ps
// How it works
// - Error query on an empty store returns code zero.
// - Codes -100 to -199 set event status bit 5.
// - Codes -200 to -299 set event status bit 4.
// - Codes -300 to -399 and positive codes set event status bit 3.
// - Codes -400 to -499 set event status bit 2.
// - A command fault produces no other class in the same event.
// - An execution fault produces no other class in the same event.
// - Execution faults are committed only once evaluation and rounding finish.
// - Each class falls back to its generic code when nothing specific fits.
// - Trigger arriving inside a program message gives -105.
// - Header over twelve characters gives -112.
// - Mantissa over 255 significant digits gives -124.
// - Suffix over twelve characters gives -134.
// - Extra parameters give -108, missing parameters give -109.
// - Legal but unimplemented header gives -113.
// - Numeric element faults use -120 to -129, generic -120.
// - Invalid character -101, syntax -102, bad separator -103.
// - Numeric not allowed -128, exponent overflow -123.
// - Invalid character data -141, character data not allowed -148.
// - Unspecific string fault gives -150.
// - Reading absent output or losing output raises a query error.
// - Thirty-entry queue, newest dropped, last slot holds -350 on overflow.
// - Each error query returns and removes the oldest entry.
// - Queue empties at reset, clear-status, and last entry read.
module pec_classifier
   import pec_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdData,
   input pec_syntax_s syntaxFault,
   input pec_len_s lenCheck,
   input wire logic trigRcvd,
   input wire logic inProgMsg,
   input pec_fault_s execFault,
   input wire logic evalDone,
   input pec_fault_s devFault,
   input wire logic qryNoOutput,
   input wire logic qryLost,
   output logic [7:0] eventStatus,
   output logic errPending
);
   // ==========================================================
   // Register decode
   logic esrRead;
   logic errqRead;
   logic qstatRead;
   logic clearStatus;
   assign esrRead = regRd && regAddr == REG_EVENT_STATUS;
   assign errqRead = regRd && regAddr == REG_ERR_QUERY;
   assign qstatRead = regRd && regAddr == REG_QUEUE_STATUS;
   assign clearStatus = regWr && regAddr == REG_CONTROL && regWrData[CTRL_CLEAR_BIT];

   // ==========================================================
   // Command class
   logic trigInMsg;
   logic hdrTooLong;
   logic digitsTooMany;
   logic sfxTooLong;
   logic cmdHit;
   pec_code_t cmdCode;

   // Length checks only count once the parser closes an element
   assign trigInMsg = trigRcvd && inProgMsg;
   assign hdrTooLong = lenCheck.strobe && lenCheck.hdrLen > MAX_MNEM_LEN;
   assign digitsTooMany = lenCheck.strobe && lenCheck.digits > MAX_DIGITS;
   assign sfxTooLong = lenCheck.strobe && lenCheck.sfxLen > MAX_SFX_LEN;
   assign cmdHit = trigInMsg || hdrTooLong || digitsTooMany || sfxTooLong || (|syntaxFault);

   // Fixed priority: the first matching cause names the event
   assign cmdCode = trigInMsg ? TRIG_IN_MSG :
                    hdrTooLong ? MNEM_LONG :
                    digitsTooMany ? TOO_MANY_DIGITS :
                    sfxTooLong ? SFX_LONG :
                    syntaxFault.invalidChar ? INVALID_CHAR :
                    syntaxFault.syntaxErr ? SYNTAX_ERR :
                    syntaxFault.invalidSep ? INVALID_SEP :
                    syntaxFault.dataType ? DATA_TYPE :
                    syntaxFault.paramExtra ? PARAM_EXTRA :
                    syntaxFault.paramMissing ? PARAM_MISSING :
                    syntaxFault.undefHdr ? UNDEF_HDR :
                    syntaxFault.numBadChar ? NUM_BAD_CHAR :
                    syntaxFault.expTooLarge ? EXP_TOO_LARGE :
                    syntaxFault.numNotAllowed ? NUM_NOT_ALLOWED :
                    syntaxFault.numGeneric ? NUM_GENERIC :
                    syntaxFault.sfxInvalid ? SFX_INVALID :
                    syntaxFault.charInvalid ? CHAR_INVALID :
                    syntaxFault.charNotAllowed ? CHAR_NOT_ALLOWED :
                    syntaxFault.strGeneric ? STR_GENERIC :
                    CMD_GENERIC;

   // ==========================================================
   // Execution class, held until evaluation is complete
   logic execPend_reg;
   logic execPend_next;
   logic execHit;
   pec_code_t execCode_reg;
   pec_code_t execCode_next;
   pec_code_t execRaw;
   pec_code_t execCode;
   logic [7:0] execMask;
   logic [7:0] devMask;

   assign execHit = evalDone && (execFault.valid || execPend_reg);
   assign execRaw = execFault.valid ? execFault.code : execCode_reg;
   assign execMask = pec_class_mask(execRaw);
   assign execCode = execMask[ESR_EXEC_BIT] ? execRaw : EXEC_GENERIC;

   // A command fault in the same cycle keeps the execution fault waiting
   assign execPend_next = clearStatus ? 1'b0 :
                          (execHit && !cmdHit) ? 1'b0 :
                          (execFault.valid || execPend_reg);
   assign execCode_next = execFault.valid ? execFault.code : execCode_reg;

   // Rounding alone never raises a fault: only an explicit fault is held
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         execPend_reg <= 1'b0;
         execCode_reg <= NO_ERROR;
      end else begin
         execPend_reg <= execPend_next;
         execCode_reg <= execCode_next;
      end
   end

   // ==========================================================
   // Device and query classes
   logic devHit;
   logic qryHit;
   pec_code_t devCode;
   assign devHit = devFault.valid;
   assign devMask = pec_class_mask(devFault.code);
   assign devCode = devMask[ESR_DEV_BIT] ? devFault.code : DEV_GENERIC;
   assign qryHit = qryNoOutput || qryLost;

   // ==========================================================
   // Event selection, one class per event
   logic evtValid;
   pec_code_t evtCode;
   logic [7:0] evtMask;

   // Same-cycle device and query faults of lower classes are dropped, not merged; an execution fault waits
   assign evtValid = cmdHit || execHit || devHit || qryHit;
   assign evtCode = cmdHit ? cmdCode :
                    execHit ? execCode :
                    devHit ? devCode :
                    qryHit ? QRY_GENERIC :
                    NO_ERROR;
   assign evtMask = evtValid ? pec_class_mask(evtCode) : 8'h00;

   // ==========================================================
   // Event status register
   logic [7:0] esr_reg;
   logic [7:0] esr_next;

   // Read clears the register, a new event in that cycle still sets
   assign esr_next = ((esrRead || clearStatus) ? 8'h00 : esr_reg) | evtMask;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         esr_reg <= ESR_RESET;
      end else begin
         esr_reg <= esr_next;
      end
   end

   // ==========================================================
   // Error queue
   pec_code_t headCode;
   logic [QPTR_W-1:0] qCount;

   pec_err_queue u_queue (
      .clk(clk),
      .sys_rst(sys_rst),
      .clr(clearStatus),
      .push(evtValid),
      .pushCode(evtCode),
      .pop(errqRead),
      .headCode(headCode),
      .count(qCount)
   );

   // ==========================================================
   // Read data and status outputs
   logic [DATA_W-1:0] rdData_reg;
   logic [DATA_W-1:0] rdData_next;
   logic [7:0] eventStatus_reg;
   logic errPending_reg;

   // Data stands one cycle only, zero otherwise and for unmapped reads
   assign rdData_next = esrRead ? {24'h000000, esr_reg} :
                        errqRead ? {{(DATA_W-CODE_W){headCode[CODE_W-1]}}, headCode} :
                        qstatRead ? {{(DATA_W-QPTR_W){1'b0}}, qCount} :
                        '0;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdData_reg <= '0;
         eventStatus_reg <= ESR_RESET;
         errPending_reg <= 1'b0;
      end else begin
         rdData_reg <= rdData_next;
         eventStatus_reg <= esr_next;
         errPending_reg <= (qCount != '0);
      end
   end

   assign regRdData = rdData_reg;
   assign eventStatus = eventStatus_reg;
   assign errPending = errPending_reg;

   // ==========================================================
   // Checks
   a_empty_reads_zero: assert property (@(posedge clk) disable iff (sys_rst)
      (errqRead && qCount == '0) |=> regRdData == '0)
      else $error("empty error query did not read zero");

   a_cmd_sets_bit5: assert property (@(posedge clk) disable iff (sys_rst)
      (evtValid && evtCode <= CMD_HI && evtCode >= CMD_LO) |=> eventStatus[5])
      else $error("command code did not set bit 5");

   a_exec_sets_bit4: assert property (@(posedge clk) disable iff (sys_rst)
      (execHit && !cmdHit) |=> (eventStatus[4] && !eventStatus_reg[5] || $past(esr_reg[5])))
      else $error("execution fault did not set bit 4 alone");

   a_dev_sets_bit3: assert property (@(posedge clk) disable iff (sys_rst)
      (devHit && !cmdHit && !execHit) |=> eventStatus[3])
      else $error("device fault did not set bit 3");

   a_qry_sets_bit2: assert property (@(posedge clk) disable iff (sys_rst)
      (qryHit && !cmdHit && !execHit && !devHit) |=> eventStatus[2])
      else $error("query fault did not set bit 2");

   a_single_class: assert property (@(posedge clk) disable iff (sys_rst)
      evtValid |-> $onehot(evtMask))
      else $error("event raised more than one class");

   a_exec_after_eval: assert property (@(posedge clk) disable iff (sys_rst)
      (execFault.valid && !evalDone && !cmdHit && !clearStatus) |=> execPend_reg)
      else $error("execution fault not held for evaluation");

   a_trigger_code: assert property (@(posedge clk) disable iff (sys_rst)
      trigInMsg |-> evtCode == TRIG_IN_MSG)
      else $error("trigger in message not coded -105");

   a_long_header: assert property (@(posedge clk) disable iff (sys_rst)
      (hdrTooLong && !trigInMsg) |-> evtCode == MNEM_LONG)
      else $error("long header not coded -112");

   a_queue_bound: assert property (@(posedge clk) disable iff (sys_rst)
      qCount <= QPTR_W'(QUEUE_DEPTH))
      else $error("error queue above thirty entries");

   a_read_pops: assert property (@(posedge clk) disable iff (sys_rst)
      (errqRead && qCount != '0 && !evtValid) |=> qCount == $past(qCount) - 1'b1)
      else $error("error query did not remove one entry");

   a_clear_empties: assert property (@(posedge clk) disable iff (sys_rst)
      (clearStatus && !evtValid) |=> (qCount == '0 && eventStatus == 8'h00))
      else $error("clear-status did not empty queue and status");

   a_digits_code: assert property (@(posedge clk) disable iff (sys_rst)
      (digitsTooMany && !trigInMsg && !hdrTooLong) |-> evtCode == TOO_MANY_DIGITS)
      else $error("too many digits not coded -124");

   a_suffix_code: assert property (@(posedge clk) disable iff (sys_rst)
      (sfxTooLong && !trigInMsg && !hdrTooLong && !digitsTooMany) |-> evtCode == SFX_LONG)
      else $error("long suffix not coded -134");

   a_exec_in_range: assert property (@(posedge clk) disable iff (sys_rst)
      (execHit && !cmdHit) |-> (evtCode <= EXEC_HI && evtCode >= EXEC_LO))
      else $error("execution event coded outside its class");

   a_query_code: assert property (@(posedge clk) disable iff (sys_rst)
      (qryHit && !cmdHit && !execHit && !devHit) |-> evtCode == QRY_GENERIC)
      else $error("query fault not coded -400");

   a_full_drops: assert property (@(posedge clk) disable iff (sys_rst)
      (qCount == QPTR_W'(QUEUE_DEPTH) && !errqRead && !clearStatus) |=> qCount == QPTR_W'(QUEUE_DEPTH))
      else $error("full error queue changed without a read");

   a_last_read_empties: assert property (@(posedge clk) disable iff (sys_rst)
      (errqRead && qCount == QPTR_W'(1) && !evtValid) |=> (qCount == '0) ##1 !errPending)
      else $error("reading the last entry did not empty the queue");
endmodule

/* test/pec_ctrl_model.sv */
/*
 Model of the remote controller: it drives the parser-side fault pulses.
 Assumes one clock; every pulse is launched just after a rising edge
 and lasts exactly one cycle, as the classifier takes them.
*/
`timescale 1ns/1ps
module pec_ctrl_model
   import pec_pkg::*;
(
   input wire logic clk,
   output pec_syntax_s syntaxFault,
   output pec_len_s lenCheck,
   output logic trigRcvd,
   output logic inProgMsg,
   output pec_fault_s execFault,
   output logic evalDone,
   output pec_fault_s devFault,
   output logic qryNoOutput,
   output logic qryLost
);
   // ==========================================================
   // Idle levels at time zero
   initial begin
      syntaxFault = '0;
      lenCheck = '0;
      trigRcvd = 1'b0;
      inProgMsg = 1'b0;
      execFault = '0;
      evalDone = 1'b0;
      devFault = '0;
      qryNoOutput = 1'b0;
      qryLost = 1'b0;
   end

   // ==========================================================
   // One event: all fields for one cycle, then back to idle
   // Everything drops together so no stale flag leaks into the next event
   task automatic send(input pec_syntax_s sf, input pec_len_s ln, input logic tr, input logic im,
                       input pec_fault_s ef, input logic ev, input pec_fault_s df, input logic qn,
                       input logic ql);
      @(posedge clk);
      syntaxFault <= sf;
      lenCheck <= ln;
      trigRcvd <= tr;
      inProgMsg <= im;
      execFault <= ef;
      evalDone <= ev;
      devFault <= df;
      qryNoOutput <= qn;
      qryLost <= ql;
      @(posedge clk);
      syntaxFault <= '0;
      lenCheck <= '0;
      trigRcvd <= 1'b0;
      inProgMsg <= 1'b0;
      execFault <= '0;
      evalDone <= 1'b0;
      devFault <= '0;
      qryNoOutput <= 1'b0;
      qryLost <= 1'b0;
   endtask
endmodule

/* test/tb_top.sv */
/*
 Self-checking bench for the parser error classifier.
 Assumes the register port answers one cycle after the read strobe and
 that the controller model supplies every fault input.
*/
`timescale 1ns/1ps
module tb_top
   import pec_pkg::*;
;
   logic clk;
   logic sys_rst;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] regWrData;
   logic regWr;
   logic regRd;
   logic [DATA_W-1:0] regRdData;
   pec_syntax_s syntaxFault;
   pec_len_s lenCheck;
   logic trigRcvd, inProgMsg, evalDone, qryNoOutput, qryLost;
   pec_fault_s execFault, devFault;
   logic [7:0] eventStatus;
   logic errPending;
   int fail_count = 0;
   int comparisons = 0;
   int rndSeed = 32'h21c9c950;
   logic [31:0] expQ[$];
   logic rdSeen = 1'b0;
   pec_code_t synCodes[16] = '{CMD_GENERIC, INVALID_CHAR, SYNTAX_ERR, INVALID_SEP, DATA_TYPE,
      PARAM_EXTRA, PARAM_MISSING, UNDEF_HDR, NUM_GENERIC, NUM_BAD_CHAR, EXP_TOO_LARGE,
      NUM_NOT_ALLOWED, SFX_INVALID, CHAR_INVALID, CHAR_NOT_ALLOWED, STR_GENERIC};

   pec_classifier DUT (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .syntaxFault(syntaxFault),
      .lenCheck(lenCheck), .trigRcvd(trigRcvd), .inProgMsg(inProgMsg), .execFault(execFault),
      .evalDone(evalDone), .devFault(devFault), .qryNoOutput(qryNoOutput), .qryLost(qryLost),
      .eventStatus(eventStatus), .errPending(errPending));

   pec_ctrl_model ctrl (.clk(clk), .syntaxFault(syntaxFault), .lenCheck(lenCheck),
      .trigRcvd(trigRcvd), .inProgMsg(inProgMsg), .execFault(execFault), .evalDone(evalDone),
      .devFault(devFault), .qryNoOutput(qryNoOutput), .qryLost(qryLost));

   // ==========================================================
   // Clock, 25 ns period
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ==========================================================
   // Helpers
   task automatic tally_and_finish();
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] sx(input pec_code_t c);
      return {{16{c[15]}}, c};
   endfunction

   // Read: the expectation is noted when the strobe goes out
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      expQ.push_back(e);
      @(posedge clk);
      regRd <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   // Status read clears, so each event shows only its own class bit
   task automatic chk(input pec_code_t c, input int b);
      rd(REG_EVENT_STATUS, 32'h1 << b);
      rd(REG_ERR_QUERY, sx(c));
   endtask

   // ==========================================================
   // Monitor: read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rdSeen) begin
         if (expQ.size() == 0) begin
            compare(regRdData, 32'hdeadbeef);
         end else begin
            compare(regRdData, expQ.pop_front());
         end
      end
      rdSeen <= regRd;
   end

   // Watchdog: a hang is a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      compare(32'h0, 32'h1);
      tally_and_finish();
   end

   // ==========================================================
   // Main sequence
   initial begin
      int i;
      pec_code_t c;
      sys_rst = 1'b1;
      regAddr = '0;
      regWrData = '0;
      regWr = 1'b0;
      regRd = 1'b0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rd(REG_ERR_QUERY, 32'h0);
      rd(REG_EVENT_STATUS, 32'h0);
      rd(REG_QUEUE_STATUS, 32'h0);
      wr(8'h10, 32'hffffffff);
      rd(8'h10, 32'h0);
      // Every parser flag alone, in struct order
      for (i = 0; i < 16; i++) begin
         ctrl.send(16'h8000 >> i, '0, 0, 0, '0, 0, '0, 0, 0);
         chk(synCodes[i], ESR_CMD_BIT);
      end
      // Length limits: one over, then exactly at the limit
      ctrl.send('0, {1'b1, 8'd13, 10'd0, 8'd0}, 0, 0, '0, 0, '0, 0, 0);
      chk(MNEM_LONG, ESR_CMD_BIT);
      ctrl.send('0, {1'b1, 8'd0, 10'd256, 8'd0}, 0, 0, '0, 0, '0, 0, 0);
      chk(TOO_MANY_DIGITS, ESR_CMD_BIT);
      ctrl.send('0, {1'b1, 8'd0, 10'd0, 8'd13}, 0, 0, '0, 0, '0, 0, 0);
      chk(SFX_LONG, ESR_CMD_BIT);
      ctrl.send('0, {1'b1, 8'd12, 10'd255, 8'd12}, 0, 0, '0, 0, '0, 0, 0);
      rd(REG_ERR_QUERY, 32'h0);
      // Trigger inside and outside a message
      ctrl.send('0, '0, 1, 1, '0, 0, '0, 0, 0);
      chk(TRIG_IN_MSG, ESR_CMD_BIT);
      ctrl.send('0, '0, 1, 0, '0, 0, '0, 0, 0);
      rd(REG_ERR_QUERY, 32'h0);
      // Execution fault waits for evaluation to finish
      c = EXEC_HI - pec_code_t'({$random(rndSeed)} % 100);
      ctrl.send('0, '0, 0, 0, {1'b1, c}, 0, '0, 0, 0);
      rd(REG_EVENT_STATUS, 32'h0);
      ctrl.send('0, '0, 0, 0, '0, 1, '0, 0, 0);
      chk(c, ESR_EXEC_BIT);
      ctrl.send('0, '0, 0, 0, {1'b1, -16'sd150}, 1, '0, 0, 0);
      chk(EXEC_GENERIC, ESR_EXEC_BIT);
      // Device-specific codes, negative and positive
      ctrl.send('0, '0, 0, 0, '0, 0, {1'b1, -16'sd330}, 0, 0);
      chk(-16'sd330, ESR_DEV_BIT);
      c = pec_code_t'(1 + {$random(rndSeed)} % 32767);
      ctrl.send('0, '0, 0, 0, '0, 0, {1'b1, c}, 0, 0);
      chk(c, ESR_DEV_BIT);
      // Query faults
      ctrl.send('0, '0, 0, 0, '0, 0, '0, 1, 0);
      chk(QRY_GENERIC, ESR_QRY_BIT);
      ctrl.send('0, '0, 0, 0, '0, 0, '0, 0, 1);
      chk(QRY_GENERIC, ESR_QRY_BIT);
      // Simultaneous classes: the winner alone is reported
      ctrl.send(16'h8000, '0, 0, 0, '0, 0, {1'b1, -16'sd300}, 1, 0);
      chk(CMD_GENERIC, ESR_CMD_BIT);
      rd(REG_ERR_QUERY, 32'h0);
      ctrl.send('0, '0, 0, 0, {1'b1, -16'sd222}, 1, {1'b1, -16'sd300}, 1, 0);
      chk(-16'sd222, ESR_EXEC_BIT);
      rd(REG_ERR_QUERY, 32'h0);
      // A pending execution fault waits while a command fault takes the event
      ctrl.send('0, '0, 0, 0, {1'b1, -16'sd224}, 0, '0, 0, 0);
      ctrl.send(16'h0400, '0, 0, 0, '0, 1, '0, 0, 0);
      chk(PARAM_EXTRA, ESR_CMD_BIT);
      rd(REG_ERR_QUERY, 32'h0);
      ctrl.send('0, '0, 0, 0, '0, 1, '0, 0, 0);
      chk(-16'sd224, ESR_EXEC_BIT);
      // Overflow: 31 faults, 29 kept plus the overflow marker
      for (i = 1; i <= 31; i++) begin
         ctrl.send('0, '0, 0, 0, '0, 0, {1'b1, 16'(i)}, 0, 0);
      end
      @(negedge clk);
      compare({31'd0, errPending}, 32'h1);
      compare({24'd0, eventStatus}, 32'h08);
      rd(REG_QUEUE_STATUS, 32'd30);
      for (i = 1; i <= 29; i++) begin
         rd(REG_ERR_QUERY, 32'(i));
      end
      rd(REG_ERR_QUERY, sx(QUEUE_OVERFLOW));
      rd(REG_ERR_QUERY, 32'h0);
      // Clear-status empties queue and status
      ctrl.send(16'h0001, '0, 0, 0, '0, 0, '0, 0, 0);
      wr(REG_CONTROL, 32'h1);
      rd(REG_QUEUE_STATUS, 32'h0);
      rd(REG_EVENT_STATUS, 32'h0);
      rd(REG_CONTROL, 32'h0);
      repeat (4) @(posedge clk);
      @(negedge clk);
      compare({31'd0, errPending}, 32'h0);
      compare({24'd0, eventStatus}, 32'h00);
      compare(32'(expQ.size()), 32'h0);
      tally_and_finish();
   end
endmodule
